//--- pll_limp_home_control.sv
// Purpose: PLL control registers, lock and limp-home status, stop exit sequencing
// Assumes: slow_timebase_clock is a one-cycle tick on pclk; stop_request and
//          wake_event come from pclk logic; analog status pins are asynchronous
// Notes: zero-wait APB slave, read data captured in the setup cycle
//
// Function
// - no limp, monitor off, delay set: resume on crystal after 4096 slow ticks.
// - no limp, monitor off, delay clear: resume on crystal after 16 slow ticks.
// - limp disabled and monitors off: never use limp clock, only crystal wakes.
// - limp disabled, monitor on: STOP raises clock monitor reset.
// - limp enabled, delay clear: pseudo-stop exit lands in limp-home mode.
// - bus frequency is reference times multiplier plus one.
// - reference frequency divided by divider value plus one.
// - multiplier and divider writes ignored while PLL drives bus clock.
// - test register reads zero unless in test mode.
// - lock-change flag sets on tolerance edges, write-one clears, cleared in limp.
// - read-only tolerance bit, unaffected by writes, zero in limp.
// - limp-change flag sets on limp entry or exit, write-one clears.
// - limp status reads one while limp-home mode is active, zero otherwise.
// - reset power on and no-limp clear; low supply forces them off and on.
// - lock interrupt enable gates lock flag, forced zero on low supply.
// - power bit cannot clear while PLL drives bus; limp forces power output.
// - power on with automatic bandwidth locks without software.
// - automatic mode makes bandwidth bit read-only, manual mode software-written.
// - automatic mode uses wide bandwidth far from target, narrow when close.
// - reference loss enters limp if allowed, otherwise clock monitor reset.
// - keepalive bit keeps oscillator running during stop.
// - limp interrupt enable gates limp flag, forced zero on low supply.
`timescale 1ns/10ps
module pll_limp_home_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pll_supply_level,
  input wire logic vco_in_tolerance,
  input wire logic ref_clock_present,
  input wire logic test_mode,
  input wire logic slow_timebase_clock,
  input wire logic stop_request,
  input wire logic wake_event,
  output logic pll_power_out,
  output logic wide_bw_out,
  output logic [8:0] loop_mult_factor,
  output logic [8:0] ref_div_factor,
  output logic bus_select_out,
  output logic limp_clock_select,
  output logic run_on_crystal,
  output logic cpu_halted,
  output logic osc_enable,
  output logic monitor_reset,
  output logic tol_irq,
  output logic limp_irq
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic sup_s1;
    logic sup_s2;
    logic tol_s1;
    logic tol_s2;
    logic tol_q;
    logic ref_s1;
    logic ref_s2;
    logic ref_q;
    logic tst_s1;
    logic tst_s2;
    logic [7:0] loop_multiplier_reg;
    logic [7:0] reference_divider_reg;
    logic tolie;
    logic pll_power;
    logic auto_bw;
    logic wide_loop_bandwidth;
    logic osc_keepalive_stop;
    logic limp_irq_enable;
    logic no_limp_home_select;
    logic no_limp_home_select_done;
    logic clock_monitor_enable;
    logic forced_monitor_enable;
    logic dly;
    logic bsel;
    logic tol_flag;
    logic limp_flag;
    logic limp;
    logic mon_reset;
    clkgen_pkg::mode_t mode;
    logic [12:0] cnt;
    logic [31:0] rdata;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic logic [7:0] reg_index(input logic [9:0] addr);
    reg_index = addr[9:2];
  endfunction : reg_index

  function automatic logic is_mapped(input logic [9:0] addr);
    logic [7:0] i;
    i = addr[9:2];
    is_mapped = (addr[1:0] == 2'h0) &&
      ((i >= clkgen_pkg::IDX_LOOP_MULT && i <= clkgen_pkg::IDX_CTRL) ||
       i == clkgen_pkg::IDX_CLKCFG || i == clkgen_pkg::IDX_STATUS);
  endfunction : is_mapped

  logic locked;
  assign locked = st.tol_s2 & ~st.limp;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic wr;
    logic rd_setup;
    logic [7:0] idx;
    logic [7:0] rv;
    logic [12:0] target;
    logic mon_any;
    wr = psel & penable & pwrite & is_mapped(paddr);
    rd_setup = psel & ~penable & ~pwrite;
    idx = reg_index(paddr);
    rv = 8'h00;
    target = st.dly ? clkgen_pkg::TICKS_LONG : clkgen_pkg::TICKS_SHORT;
    mon_any = st.clock_monitor_enable | st.forced_monitor_enable;
    next_st = st;
    next_st.sup_s1 = pll_supply_level;
    next_st.sup_s2 = st.sup_s1;
    next_st.tol_s1 = vco_in_tolerance;
    next_st.tol_s2 = st.tol_s1;
    next_st.tol_q = st.tol_s2;
    next_st.ref_s1 = ref_clock_present;
    next_st.ref_s2 = st.ref_s1;
    next_st.ref_q = st.ref_s2;
    next_st.tst_s1 = test_mode;
    next_st.tst_s2 = st.tst_s1;
    next_st.mon_reset = 1'b0;

    // ************************************************************
    // register writes
    // ************************************************************
    if (wr) begin
      if (idx == clkgen_pkg::IDX_LOOP_MULT && !st.bsel) begin
        next_st.loop_multiplier_reg = pwdata[7:0];
      end
      if (idx == clkgen_pkg::IDX_REF_DIV && !st.bsel) begin
        next_st.reference_divider_reg = pwdata[7:0];
      end
      if (idx == clkgen_pkg::IDX_FLAG) begin
        if (pwdata[clkgen_pkg::FLAG_TOL_CHG]) begin
          next_st.tol_flag = 1'b0;
        end
        if (pwdata[clkgen_pkg::FLAG_LIMP_CHG]) begin
          next_st.limp_flag = 1'b0;
        end
      end
      if (idx == clkgen_pkg::IDX_CTRL) begin
        next_st.tolie = pwdata[clkgen_pkg::CTRL_TOL_IE];
        // power stays on while the PLL still clocks the bus
        next_st.pll_power = pwdata[clkgen_pkg::CTRL_POWER] | st.bsel;
        next_st.auto_bw = pwdata[clkgen_pkg::CTRL_AUTO];
        if (!st.auto_bw) begin
          next_st.wide_loop_bandwidth = pwdata[clkgen_pkg::CTRL_WIDE];
        end
        next_st.osc_keepalive_stop = pwdata[clkgen_pkg::CTRL_KEEPALIVE];
        next_st.limp_irq_enable = pwdata[clkgen_pkg::CTRL_LIMP_IE];
        // write once in normal modes, anytime in test mode
        if (!st.no_limp_home_select_done || st.tst_s2) begin
          next_st.no_limp_home_select = pwdata[clkgen_pkg::CTRL_NOLIMP];
          next_st.no_limp_home_select_done = 1'b1;
        end
      end
      if (idx == clkgen_pkg::IDX_CLKCFG) begin
        next_st.clock_monitor_enable = pwdata[clkgen_pkg::CFG_CME];
        next_st.forced_monitor_enable = pwdata[clkgen_pkg::CFG_FORCED_MONITOR_ENABLE];
        next_st.dly = pwdata[clkgen_pkg::CFG_DLY];
        // the PLL cannot be picked as bus clock while it is off
        next_st.bsel = pwdata[clkgen_pkg::CFG_BSEL] & st.pll_power;
      end
    end

    // ************************************************************
    // stop, wake and limp-home sequencing
    // ************************************************************
    unique case (st.mode)
      clkgen_pkg::M_RUN: begin
        if (st.limp && slow_timebase_clock) begin
          next_st.cnt = st.cnt + 13'h0001;
          if (st.cnt == clkgen_pkg::TICKS_CHECK - 13'h0001) begin
            next_st.cnt = 13'h0000;
            if (st.ref_s2) begin
              next_st.limp = 1'b0;
            end
          end
        end
        if (!st.limp && !st.ref_s2 && !st.no_limp_home_select) begin
          next_st.limp = 1'b1;
          next_st.cnt = 13'h0000;
        end
        if (st.ref_q && !st.ref_s2 && st.no_limp_home_select) begin
          next_st.mon_reset = 1'b1;
        end
        if (stop_request) begin
          if (st.no_limp_home_select && mon_any) begin
            next_st.mon_reset = 1'b1;
          end else begin
            next_st.mode = clkgen_pkg::M_STOP;
            next_st.cnt = 13'h0000;
          end
        end
      end
      clkgen_pkg::M_STOP: begin
        if (wake_event) begin
          next_st.cnt = 13'h0000;
          if (!st.no_limp_home_select) begin
            next_st.limp = 1'b1;
            next_st.mode = st.dly ? clkgen_pkg::M_WAKE : clkgen_pkg::M_RUN;
          end else begin
            next_st.mode = clkgen_pkg::M_WAKE;
          end
        end
      end
      clkgen_pkg::M_WAKE: begin
        // without limp-home only a live crystal advances the count
        if (slow_timebase_clock && (st.limp || st.ref_s2)) begin
          next_st.cnt = st.cnt + 13'h0001;
          if (st.cnt == target - 13'h0001) begin
            next_st.mode = clkgen_pkg::M_RUN;
            next_st.cnt = 13'h0000;
            if (st.limp && st.ref_s2) begin
              next_st.limp = 1'b0;
            end
          end
        end
      end
      default: begin
        next_st.mode = clkgen_pkg::M_RUN;
      end
    endcase

    // ************************************************************
    // sticky flags: a set in the clearing cycle wins
    // ************************************************************
    if (st.tol_s2 != st.tol_q) begin
      next_st.tol_flag = 1'b1;
    end
    if (st.limp || next_st.limp) begin
      next_st.tol_flag = 1'b0;
    end
    if (next_st.limp != st.limp) begin
      next_st.limp_flag = 1'b1;
    end

    // ************************************************************
    // low PLL supply overrides
    // ************************************************************
    if (!st.sup_s2) begin
      next_st.pll_power = 1'b0;
      next_st.no_limp_home_select = 1'b1;
      next_st.tolie = 1'b0;
      next_st.limp_irq_enable = 1'b0;
    end

    // ************************************************************
    // read data, captured in the setup cycle
    // ************************************************************
    if (rd_setup) begin
      if (idx == clkgen_pkg::IDX_LOOP_MULT) begin
        rv = st.loop_multiplier_reg;
      end
      if (idx == clkgen_pkg::IDX_REF_DIV) begin
        rv = st.reference_divider_reg;
      end
      if (idx == clkgen_pkg::IDX_TEST && st.tst_s2) begin
        rv = {6'h00, st.tol_s2, st.ref_s2};
      end
      if (idx == clkgen_pkg::IDX_FLAG) begin
        rv[clkgen_pkg::FLAG_TOL_CHG] = st.tol_flag;
        rv[clkgen_pkg::FLAG_TOL] = locked;
        rv[clkgen_pkg::FLAG_LIMP_CHG] = st.limp_flag;
        rv[clkgen_pkg::FLAG_LIMP] = st.limp;
      end
      if (idx == clkgen_pkg::IDX_CTRL) begin
        rv[clkgen_pkg::CTRL_TOL_IE] = st.tolie;
        rv[clkgen_pkg::CTRL_POWER] = st.pll_power;
        rv[clkgen_pkg::CTRL_AUTO] = st.auto_bw;
        rv[clkgen_pkg::CTRL_WIDE] = st.auto_bw ? locked : st.wide_loop_bandwidth;
        rv[clkgen_pkg::CTRL_KEEPALIVE] = st.osc_keepalive_stop;
        rv[clkgen_pkg::CTRL_LIMP_IE] = st.limp_irq_enable;
        rv[clkgen_pkg::CTRL_NOLIMP] = st.no_limp_home_select;
      end
      if (idx == clkgen_pkg::IDX_CLKCFG) begin
        rv[clkgen_pkg::CFG_CME] = st.clock_monitor_enable;
        rv[clkgen_pkg::CFG_FORCED_MONITOR_ENABLE] = st.forced_monitor_enable;
        rv[clkgen_pkg::CFG_DLY] = st.dly;
        rv[clkgen_pkg::CFG_BSEL] = st.bsel;
      end
      if (idx == clkgen_pkg::IDX_STATUS) begin
        rv[clkgen_pkg::STS_HALTED] = (st.mode != clkgen_pkg::M_RUN);
        rv[clkgen_pkg::STS_WAKING] = (st.mode == clkgen_pkg::M_WAKE);
        rv[clkgen_pkg::STS_OSC_ON] = osc_enable;
      end
      next_st.rdata = {24'h000000, rv};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.sup_s1 <= 1'b1;
      st.sup_s2 <= 1'b1;
      st.ref_s1 <= 1'b1;
      st.ref_s2 <= 1'b1;
      st.ref_q <= 1'b1;
      st.loop_multiplier_reg <= clkgen_pkg::RST_LOOP_MULT;
      st.reference_divider_reg <= clkgen_pkg::RST_REF_DIV;
      st.pll_power <= clkgen_pkg::RST_POWER;
      st.auto_bw <= clkgen_pkg::RST_AUTO;
      st.no_limp_home_select <= clkgen_pkg::RST_NOLIMP;
      st.mode <= clkgen_pkg::M_RUN;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata = st.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign pll_power_out = st.pll_power | st.limp;
  // automatic mode closes the loop itself from the tolerance detector
  assign wide_bw_out = st.auto_bw ? ~locked : ~st.wide_loop_bandwidth;
  assign loop_mult_factor = {1'b0, st.loop_multiplier_reg} + 9'h001;
  assign ref_div_factor = {1'b0, st.reference_divider_reg} + 9'h001;
  assign bus_select_out = st.bsel | st.limp;
  assign limp_clock_select = st.limp;
  assign run_on_crystal = (st.mode == clkgen_pkg::M_RUN) & ~st.limp;
  assign cpu_halted = (st.mode != clkgen_pkg::M_RUN);
  assign osc_enable = (st.mode != clkgen_pkg::M_STOP) | st.osc_keepalive_stop;
  assign monitor_reset = st.mon_reset;
  assign tol_irq = st.tol_flag & st.tolie;
  assign limp_irq = st.limp_flag & st.limp_irq_enable;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wake_done;
    st.mode == clkgen_pkg::M_WAKE && slow_timebase_clock && st.no_limp_home_select && st.ref_s2
      && st.cnt == (st.dly ? clkgen_pkg::TICKS_LONG : clkgen_pkg::TICKS_SHORT) - 13'h0001;
  endsequence

  sequence s_locked_write;
    psel && penable && pwrite && st.bsel
      && reg_index(paddr) == clkgen_pkg::IDX_LOOP_MULT;
  endsequence

  chk_exit_delay: assert property (s_wake_done |=> run_on_crystal)
    else $error("stop exit not on crystal after slow tick count");
  chk_mult_locked: assert property (s_locked_write |=> $stable(st.loop_multiplier_reg))
    else $error("loop multiplier changed while PLL drives bus");
  chk_test_zero: assert property (psel && !penable && !pwrite && !st.tst_s2
      && reg_index(paddr) == clkgen_pkg::IDX_TEST |=> prdata == 32'h00000000)
    else $error("test register read nonzero outside test mode");
  chk_tol_edge: assert property ($changed(st.tol_s2) && !st.limp
      && !$rose(st.limp) |=> st.tol_flag || st.limp)
    else $error("tolerance change flag not set");
  chk_tol_limp: assert property (st.limp |=> !st.tol_flag)
    else $error("tolerance change flag set in limp mode");
  chk_limp_flag: assert property ($changed(st.limp) |-> st.limp_flag)
    else $error("limp change flag not set on limp change");
  chk_power_limp: assert property (st.limp |-> pll_power_out)
    else $error("PLL power output off in limp mode");
  chk_monitor_stop: assert property (st.mode == clkgen_pkg::M_RUN && stop_request
      && st.no_limp_home_select && (st.clock_monitor_enable || st.forced_monitor_enable) |=> monitor_reset && !cpu_halted)
    else $error("stop with monitor on did not raise monitor reset");
  chk_no_limp: assert property (st.no_limp_home_select && !st.limp && st.mode != clkgen_pkg::M_RUN
      |=> !st.limp)
    else $error("limp clock used with limp-home disabled");
  chk_supply_low: assert property (!st.sup_s2 |=> !st.pll_power && st.no_limp_home_select
      && !tol_irq && !limp_irq)
    else $error("low supply did not force control bits");
  chk_irq_gate: assert property (tol_irq |-> st.tol_flag && st.tolie)
    else $error("lock interrupt without flag and enable");

endmodule : pll_limp_home_control

//--- clkgen_pkg.sv
// Purpose: shared constants and types of the PLL and limp-home control block
// Assumes: byte-wide registers, each in one aligned APB word at four times its index
// Notes: indices 0x3F and 0x40 hold the extra configuration and status bits
package clkgen_pkg;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_LOOP_MULT = 8'h38;
  localparam logic [7:0] IDX_REF_DIV = 8'h39;
  localparam logic [7:0] IDX_TEST = 8'h3A;
  localparam logic [7:0] IDX_FLAG = 8'h3B;
  localparam logic [7:0] IDX_CTRL = 8'h3C;
  localparam logic [7:0] IDX_CLKCFG = 8'h3F;
  localparam logic [7:0] IDX_STATUS = 8'h40;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int FLAG_TOL_CHG = 7;
  localparam int FLAG_TOL = 6;
  localparam int FLAG_LIMP_CHG = 1;
  localparam int FLAG_LIMP = 0;
  localparam int CTRL_TOL_IE = 7;
  localparam int CTRL_POWER = 6;
  localparam int CTRL_AUTO = 5;
  localparam int CTRL_WIDE = 4;
  localparam int CTRL_KEEPALIVE = 2;
  localparam int CTRL_LIMP_IE = 1;
  localparam int CTRL_NOLIMP = 0;
  localparam int CFG_CME = 0;
  localparam int CFG_FORCED_MONITOR_ENABLE = 1;
  localparam int CFG_DLY = 2;
  localparam int CFG_BSEL = 3;
  localparam int STS_HALTED = 0;
  localparam int STS_WAKING = 1;
  localparam int STS_OSC_ON = 2;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic RST_POWER = 1'b1;
  localparam logic RST_AUTO = 1'b1;
  localparam logic RST_NOLIMP = 1'b0;
  localparam logic [7:0] RST_LOOP_MULT = 8'h00;
  localparam logic [7:0] RST_REF_DIV = 8'h00;

  // ************************************************************
  // slow timebase counts
  // ************************************************************
  localparam logic [12:0] TICKS_LONG = 13'h1000;
  localparam logic [12:0] TICKS_SHORT = 13'h0010;
  localparam logic [12:0] TICKS_CHECK = 13'h1000;

  typedef enum logic [1:0] {M_RUN, M_STOP, M_WAKE} mode_t;

endpackage : clkgen_pkg

//--- osc_vco_model.sv
// Purpose: crystal oscillator and VCO stand-in for the PLL control block
// Assumes: slow timebase tick every TICK_DIV pclk cycles
// Notes: tolerance is reported only after a spell with power and reference present
`timescale 1ns/10ps
module osc_vco_model #(
  parameter int TICK_DIV = 2,
  parameter int LOCK_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic crystal_ok,
  input wire logic pll_power_out,
  output logic vco_in_tolerance,
  output logic ref_clock_present,
  output logic slow_timebase_clock
);
  int div_cnt;
  int lock_cnt;
  assign ref_clock_present = crystal_ok;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 0;
      lock_cnt <= 0;
      slow_timebase_clock <= 1'b0;
      vco_in_tolerance <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
      slow_timebase_clock <= (div_cnt == TICK_DIV - 1);
      // a lost reference or a powered-down loop clears the lock count at once and drops tolerance one pclk cycle later
      if (!pll_power_out || !crystal_ok)
        lock_cnt <= 0;
      else if (lock_cnt < LOCK_CYCLES)
        lock_cnt <= lock_cnt + 1;
      vco_in_tolerance <= (lock_cnt == LOCK_CYCLES);
    end
  end
endmodule : osc_vco_model

//--- pll_limp_home_control_tb_top.sv
// Purpose: self-checking bench of the PLL and limp-home control block
// Assumes: zero-wait APB slave, analog side from osc_vco_model
// Notes: no-limp bit is write-once, so limp scenarios run before it is set
`timescale 1ns/10ps
module pll_limp_home_control_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pll_supply_level, test_mode;
  logic stop_request, wake_event, crystal_ok, last_err;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, pll_power_out, wide_bw_out, bus_select_out, limp_clock_select;
  logic run_on_crystal, cpu_halted, osc_enable, monitor_reset, tol_irq, limp_irq;
  logic vco_in_tolerance, ref_clock_present, slow_timebase_clock;
  logic [8:0] loop_mult_factor, ref_div_factor;
  logic [7:0] m, d, rv;
  logic [4:0] obs;
  int miscompares = 0;
  int checks_done = 0;
  int ticks, k, n, dly;
  assign obs = {vco_in_tolerance, monitor_reset, cpu_halted, limp_clock_select, run_on_crystal};

  pll_limp_home_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pll_supply_level(pll_supply_level), .vco_in_tolerance(vco_in_tolerance),
    .ref_clock_present(ref_clock_present), .test_mode(test_mode),
    .slow_timebase_clock(slow_timebase_clock), .stop_request(stop_request),
    .wake_event(wake_event), .pll_power_out(pll_power_out), .wide_bw_out(wide_bw_out),
    .loop_mult_factor(loop_mult_factor), .ref_div_factor(ref_div_factor),
    .bus_select_out(bus_select_out), .limp_clock_select(limp_clock_select),
    .run_on_crystal(run_on_crystal), .cpu_halted(cpu_halted), .osc_enable(osc_enable),
    .monitor_reset(monitor_reset), .tol_irq(tol_irq), .limp_irq(limp_irq));

  osc_vco_model model (.pclk(pclk), .presetn(presetn), .crystal_ok(crystal_ok),
    .pll_power_out(pll_power_out), .vco_in_tolerance(vco_in_tolerance),
    .ref_clock_present(ref_clock_present), .slow_timebase_clock(slow_timebase_clock));

  // ******************************
  // bench tasks
  // ******************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : chk

  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask : tick

  task automatic wait_obs(input int b, input logic v, input int lim);
    int w;
    w = 0;
    while (obs[b] !== v && w < lim) begin
      @(posedge pclk);
      w++;
    end
    if (obs[b] !== v) begin
      $display("ERROR wait on status %0d expected %0b seen %0b", b, v, obs[b]);
      miscompares++;
      report_and_stop();
    end
  endtask : wait_obs

  // holds the request until pready is seen high with psel and penable
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int w;
    w = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    if (w >= 50) begin
      miscompares++;
      report_and_stop();
    end
    rv = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, {8'h00, exp}, {8'h00, rv});
  endtask : rdchk

  task automatic pulse(input logic wake);
    @(posedge pclk);
    if (wake) wake_event <= 1'b1;
    else stop_request <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
    stop_request <= 1'b0;
  endtask : pulse

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ******************************
  // main sequence
  // ******************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, test_mode, stop_request, wake_event} = '0;
    presetn = 1'b0;
    pll_supply_level = 1'b1;
    crystal_ok = 1'b1;
    void'($urandom(62));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("control reset", clkgen_pkg::IDX_CTRL, 8'h60);
    rdchk("test reg", clkgen_pkg::IDX_TEST, 8'h00);
    wait_obs(4, 1'b1, 200);
    tick(8);
    rdchk("flags locked", clkgen_pkg::IDX_FLAG, 8'hC0);
    chk("auto bandwidth", 16'h0000, {15'h0, wide_bw_out});
    apb(1'b1, clkgen_pkg::IDX_CTRL, 8'hE0);
    tick(1);
    chk("lock irq", 16'h0001, {15'h0, tol_irq});
    apb(1'b1, clkgen_pkg::IDX_FLAG, 8'hFF);
    rdchk("flags cleared", clkgen_pkg::IDX_FLAG, 8'h40);
    apb(1'b1, clkgen_pkg::IDX_CTRL, 8'hC0);
    tick(1);
    chk("manual wide", 16'h0001, {15'h0, wide_bw_out});
    apb(1'b1, clkgen_pkg::IDX_CTRL, 8'hD0);
    tick(1);
    chk("manual narrow", 16'h0000, {15'h0, wide_bw_out});
    apb(1'b1, clkgen_pkg::IDX_CTRL, 8'hE0);
    for (int i = 0; i < 4; i++) begin
      m = 8'($urandom);
      d = (i == 0) ? 8'hFF : 8'($urandom);
      apb(1'b1, clkgen_pkg::IDX_LOOP_MULT, m);
      apb(1'b1, clkgen_pkg::IDX_REF_DIV, d);
      tick(1);
      chk("mult factor", {7'h0, m} + 16'h0001, {7'h0, loop_mult_factor});
      chk("div factor", {7'h0, d} + 16'h0001, {7'h0, ref_div_factor});
    end
    apb(1'b1, clkgen_pkg::IDX_CLKCFG, 8'h08);
    apb(1'b1, clkgen_pkg::IDX_LOOP_MULT, ~m);
    chk("bus select", 16'h0001, {15'h0, bus_select_out});
    rdchk("mult locked out", clkgen_pkg::IDX_LOOP_MULT, m);
    apb(1'b1, clkgen_pkg::IDX_CTRL, 8'hA0);
    rdchk("power kept", clkgen_pkg::IDX_CTRL, 8'hF0);
    apb(1'b1, clkgen_pkg::IDX_CLKCFG, 8'h00);
    apb(1'b0, 8'h3D, 8'h00);
    chk("unmapped error", 16'h0001, {15'h0, last_err});
    // reference loss with limp allowed
    apb(1'b1, clkgen_pkg::IDX_CTRL, 8'hE2);
    crystal_ok <= 1'b0;
    wait_obs(1, 1'b1, 20);
    tick(4);
    rdchk("flags in limp", clkgen_pkg::IDX_FLAG, 8'h03);
    chk("limp irq", 16'h0001, {15'h0, limp_irq});
    apb(1'b1, clkgen_pkg::IDX_CTRL, 8'hA2);
    rdchk("latched power", clkgen_pkg::IDX_CTRL, 8'hA2);
    chk("forced power", 16'h0001, {15'h0, pll_power_out});
    chk("forced bus select", 16'h0001, {15'h0, bus_select_out});
    crystal_ok <= 1'b1;
    wait_obs(1, 1'b0, 9000);
    // power bit is off, so tolerance drops a few cycles after limp ends
    tick(8);
    apb(1'b1, clkgen_pkg::IDX_FLAG, 8'h82);
    rdchk("flags after limp", clkgen_pkg::IDX_FLAG, 8'h00);
    // pseudo-stop exit through limp with delay
    apb(1'b1, clkgen_pkg::IDX_CTRL, 8'h64);
    apb(1'b1, clkgen_pkg::IDX_CLKCFG, 8'h04);
    pulse(1'b0);
    tick(2);
    chk("osc kept", 16'h0001, {15'h0, osc_enable});
    pulse(1'b1);
    tick(3);
    chk("wake in limp", 16'h0001, {15'h0, limp_clock_select});
    wait_obs(0, 1'b1, 9000);
    chk("limp left", 16'h0000, {15'h0, limp_clock_select});
    // no limp-home, monitor off: exit after a fixed tick count
    // no-limp bit was used up by the first control write: test mode reopens it
    test_mode <= 1'b1;
    tick(3);
    rdchk("test reg in test mode", clkgen_pkg::IDX_TEST, 8'h03);
    apb(1'b1, clkgen_pkg::IDX_CTRL, 8'h65);
    test_mode <= 1'b0;
    for (dly = 1; dly >= 0; dly--) begin
      n = dly ? 4096 : 16;
      apb(1'b1, clkgen_pkg::IDX_CLKCFG, dly ? 8'h04 : 8'h00);
      pulse(1'b0);
      tick(2);
      chk("halted", 16'h0001, {15'h0, cpu_halted});
      pulse(1'b1);
      ticks = 0;
      k = 0;
      while (run_on_crystal !== 1'b1 && k < 10000) begin
        @(posedge pclk);
        k++;
        if (slow_timebase_clock === 1'b1) ticks++;
        if (limp_clock_select !== 1'b0) n = -1;
      end
      chk("exit ticks", 16'(n), (ticks >= n - 2 && ticks <= n + 2) ? 16'(n) : 16'(ticks));
    end
    apb(1'b1, clkgen_pkg::IDX_CLKCFG, 8'h01);
    pulse(1'b0);
    wait_obs(3, 1'b1, 6);
    tick(1);
    chk("no halt", 16'h0000, {15'h0, cpu_halted});
    crystal_ok <= 1'b0;
    wait_obs(3, 1'b1, 10);
    crystal_ok <= 1'b1;
    apb(1'b1, clkgen_pkg::IDX_CTRL, 8'hE2);
    pll_supply_level <= 1'b0;
    tick(6);
    rdchk("low supply", clkgen_pkg::IDX_CTRL, 8'h21);
    report_and_stop();
  end
endmodule : pll_limp_home_control_tb_top
